/* fpr_fan_model.sv */
// Purpose: Behavioural cooling fan that answers with tach transitions at a fixed rate.
// Assumes: The fan is always powered, as a fan on a linear supply would be.
// Notes:   A short inverted spike sits in mid half period to exercise the input filter.
`timescale 1ns/1ps
module fpr_fan_model #(
	parameter int HALF_CLKS   = 1662,
	parameter int GLITCH_CLKS = 50
) (
	input  wire logic clk_sys,
	input  wire logic sys_rst,
	output logic      tach_pin
);
	int   cnt_r;
	int   cnt_nxt;
	logic level_r;
	logic level_nxt;
	logic spike;

	always_comb begin
		cnt_nxt   = cnt_r + 1;
		level_nxt = level_r;
		if (cnt_r == HALF_CLKS - 1) begin
			cnt_nxt   = 0;
			level_nxt = ~level_r;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_r   <= 0;
			level_r <= 1'h1;
		end else begin
			cnt_r   <= cnt_nxt;
			level_r <= level_nxt;
		end
	end

	// Real tach lines ring; a spike shorter than one tick must never count as an edge.
	assign spike    = (cnt_r >= HALF_CLKS / 2) && (cnt_r < HALF_CLKS / 2 + GLITCH_CLKS);
	assign tach_pin = spike ? ~level_r : level_r;
endmodule

/* fpr_tach.sv */
// Purpose: Shared constants for the fan PWM ramp and tach monitor, and the tach channel.
// Assumes: One system clock; tick_90k is a one-cycle pulse at the 90 kHz measuring rate.
// Notes:   The tach channel implements the period counter, always-monitoring (mode 1) or PWM-gated (mode 2).
package fpr_pkg;
	localparam int unsigned CLK_HZ     = 25_000_000;
	localparam int unsigned TICK_HZ    = 90_000;
	localparam int unsigned TICK_DIV   = CLK_HZ / TICK_HZ;
	localparam int unsigned STEP_MS [8] = '{206, 104, 69, 41, 26, 18, 10, 5};
	localparam logic [4:0]  A_PWM_CTRL = 5'h00;
	localparam logic [4:0]  A_DUTY     = 5'h04;
	localparam logic [4:0]  A_PRESENT  = 5'h08;
	localparam logic [4:0]  A_OUT_DUTY = 5'h0C;
	localparam logic [4:0]  A_TACH_CFG = 5'h10;
	localparam logic [4:0]  A_TACH_RD  = 5'h14;
	localparam logic [4:0]  A_TACH_ST  = 5'h18;
	localparam logic [4:0]  A_TACH_LIM = 5'h1C;
	localparam int          PC_RAMP_EN = 0;
	localparam int          PC_STEP_TO_OFF_ENABLE    = 1;
	localparam int          PC_SEL_LO  = 2;
	localparam int          TC_MODE    = 0;
	localparam int          TC_SLOW    = 1;
	localparam int          TC_EDGE_LO = 2;
	localparam int          TC_IGN3    = 4;
	localparam int          TC_GUARD_LO = 5;
	localparam int          TC_UPD_LO  = 11;
	localparam logic [15:0] TACH_MAX   = 16'hFFFF;
	localparam logic [15:0] TACH_SLOW  = 16'hFFFE;
	localparam logic [15:0] LIM_RST    = 16'hFFFF;
	localparam logic        MODE_RST   = 1'b1;
	localparam logic        SLOW_RST   = 1'b0;
	localparam logic [1:0]  EDGE_RST   = 2'h2;
	localparam logic        IGN3_RST   = 1'b0;
	localparam logic [5:0]  GUARD_RST  = 6'h20;
	localparam logic [1:0]  UPD_RST    = 2'h2;
	localparam logic [7:0]  DUTY_OFF   = 8'h00;
	typedef enum logic {FPR_T_IDLE, FPR_T_COUNT} fpr_tstate_t;

	function automatic logic [3:0] fpr_edges_needed(input logic [1:0] sel);
		case (sel)
			2'h0:    fpr_edges_needed = 4'h2;
			2'h1:    fpr_edges_needed = 4'h3;
			2'h2:    fpr_edges_needed = 4'h5;
			default: fpr_edges_needed = 4'h9;
		endcase
	endfunction
endpackage

`timescale 1ns/1ps
module fpr_tach
	import fpr_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	input  wire logic        clk_en,
	input  wire logic        tick_90k,
	input  wire logic        tach_pin,
	input  wire logic        mode_sel,
	input  wire logic        slow_opt,
	input  wire logic [1:0]  edge_sel,
	input  wire logic        pwm_high,
	output logic      [15:0] reading,
	output logic             slow_evt,
	output logic             stall_evt
);
	import fpr_pkg::*;

	logic        sync1_r, sync2_r;
	logic [2:0]  samp_r, samp_nxt;
	logic        filt_r, filt_nxt;
	fpr_tstate_t st_r, st_nxt;
	logic [15:0] cnt_r, cnt_nxt, rd_r, rd_nxt;
	logic [3:0]  edges_r, edges_nxt;
	logic        slow_nxt, stall_nxt, slow_r, stall_r;
	logic        edge_seen, active;

	assign edge_seen = tick_90k && (filt_nxt != filt_r);
	// Mode 2 only looks at the tach while the fan is powered.
	assign active    = !mode_sel || pwm_high;
	assign reading   = rd_r;
	assign slow_evt  = slow_r;
	assign stall_evt = stall_r;

	always_comb begin
		samp_nxt = samp_r;
		filt_nxt = filt_r;
		if (tick_90k) begin
			samp_nxt = {samp_r[1:0], sync2_r};
			// A level is accepted only after three equal samples, so short spikes vanish.
			if (samp_nxt == 3'b111)
				filt_nxt = 1'b1;
			else if (samp_nxt == 3'b000)
				filt_nxt = 1'b0;
		end
	end

	always_comb begin
		st_nxt    = st_r;
		cnt_nxt   = cnt_r;
		edges_nxt = edges_r;
		rd_nxt    = rd_r;
		slow_nxt  = 1'b0;
		stall_nxt = 1'b0;
		if (!active) begin
			st_nxt = FPR_T_IDLE;
		end else case (st_r)
			FPR_T_IDLE: begin
				if (edge_seen) begin
					st_nxt    = FPR_T_COUNT;
					cnt_nxt   = 16'h0000;
					edges_nxt = 4'h1;
				end
			end
			FPR_T_COUNT: begin
				if (tick_90k) begin
					if (edge_seen && (edges_r + 4'h1 == fpr_edges_needed(edge_sel))) begin
						rd_nxt = cnt_r;
						st_nxt = FPR_T_IDLE;
					end else if (cnt_r == TACH_MAX) begin
						st_nxt = FPR_T_IDLE;
						if (edges_r == 4'h1 && !edge_seen) begin
							rd_nxt    = TACH_MAX;
							stall_nxt = 1'b1;
						end else begin
							rd_nxt   = slow_opt ? TACH_MAX : TACH_SLOW;
							slow_nxt = 1'b1;
						end
					end else begin
						cnt_nxt = cnt_r + 16'h0001;
						if (edge_seen)
							edges_nxt = edges_r + 4'h1;
					end
				end
			end
			default: st_nxt = FPR_T_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			samp_r  <= 3'b000;
			filt_r  <= 1'b0;
			st_r    <= FPR_T_IDLE;
			cnt_r   <= 16'h0000;
			edges_r <= 4'h0;
			rd_r    <= TACH_MAX;
			slow_r  <= 1'b0;
			stall_r <= 1'b0;
		end else if (clk_en) begin
			sync1_r <= tach_pin;
			sync2_r <= sync1_r;
			samp_r  <= samp_nxt;
			filt_r  <= filt_nxt;
			st_r    <= st_nxt;
			cnt_r   <= cnt_nxt;
			edges_r <= edges_nxt;
			rd_r    <= rd_nxt;
			slow_r  <= slow_nxt;
			stall_r <= stall_nxt;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	sequence s_last_edge;
		clk_en && active && st_r == FPR_T_COUNT && edge_seen
			&& (edges_r + 4'h1 == fpr_edges_needed(edge_sel));
	endsequence
	sequence s_full_no_edge;
		clk_en && active && st_r == FPR_T_COUNT && tick_90k && !edge_seen
			&& cnt_r == TACH_MAX;
	endsequence

	a_count_latch: assert property (s_last_edge |=> rd_r == $past(cnt_r) && st_r == FPR_T_IDLE)
		else $error("tach count not latched on last edge");
	a_stall_value: assert property (s_full_no_edge ##0 edges_r == 4'h1 |=> rd_r == TACH_MAX && stall_r)
		else $error("stalled fan not reported");
	a_slow_code: assert property (s_full_no_edge ##0 edges_r > 4'h1 ##0 !slow_opt |=> rd_r == TACH_SLOW && slow_r)
		else $error("slow fan code wrong");
	a_filter_tick: assert property ($changed(filt_r) |-> $past(tick_90k && clk_en))
		else $error("filtered tach moved off tick");
endmodule

/* fpr_top.sv */
// Purpose: Fan PWM with ramp-rate control and one tach monitor behind an Avalon-MM slave.
// Assumes: clk_sys at 25 MHz; tach pin is asynchronous; one PWM and one tach channel.
// Notes:   Ramp, output duty and tach logic advance on an internal 90 kHz tick; the duty register follows bus writes.
// Behaviour
// - Duty leaving zero loads ramp duty directly and updates present duty.
// - Zero-to-nonzero only arises from a zero minimum, manual or automatic.
// - Step-to-off bit clear drops output at once; set ramps down.
// - Manual writes of zero from nonzero trigger the off transition.
// - Three-bit ramp select picks step time 206 down to 5 ms.
// - Output duty captures ramp duty at each PWM rising edge.
// - Calculated, ramp and output duties all run on the 90 kHz clock; here calculated duty is written on the bus cycle, off the tick.
// - Tach mode bit: 0 continuous mode 1, 1 (reset) PWM-gated mode 2.
// - Tach input is glitch filtered before edge detection.
// - Defaults: limit all ones, force slow code, guard 32 ticks.
// - Defaults: five edges, no ignore of first three, one-second update.
// - Mode 1 counts 90 kHz ticks between programmed edges, ungated.
// - Counter starts at first edge, runs to last edge or maximum.
// - All edges by maximum count loads reading with the count.
// - Maximum with no further edge gives stall, reading all ones.
// - Some edges but too few flags slow fan and forces code.
// - Edge count programmable; slow code forcing defaults on.
// - With ramping on, ramp duty steps one count toward calculated duty.
// - Slow option 0 forces slow code, 1 forces all ones.
//
// Our own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
module fpr_top
	import fpr_pkg::*;
#(
	parameter int unsigned STEP_TICKS [8] = '{
		STEP_MS[0] * TICK_HZ / 1000, STEP_MS[1] * TICK_HZ / 1000,
		STEP_MS[2] * TICK_HZ / 1000, STEP_MS[3] * TICK_HZ / 1000,
		STEP_MS[4] * TICK_HZ / 1000, STEP_MS[5] * TICK_HZ / 1000,
		STEP_MS[6] * TICK_HZ / 1000, STEP_MS[7] * TICK_HZ / 1000}
)
(
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	input  wire logic        clk_en,
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        tach_pin,
	output logic             pwm_out
);
	import fpr_pkg::*;

	logic [8:0]  div_r, div_nxt;
	logic        tick;
	logic [7:0]  pctl_r, pctl_nxt;
	logic [7:0]  calc_r, calc_nxt, prev_calc_r, prev_calc_nxt;
	logic [7:0]  ramp_r, ramp_nxt, out_r, out_nxt, pcnt_r, pcnt_nxt;
	logic [14:0] step_r, step_nxt;
	logic        step_hit;
	logic [12:0] tcfg_r, tcfg_nxt;
	logic [15:0] lim_r, lim_nxt;
	logic [1:0]  tst_r, tst_nxt;
	logic        ack_r, ack_nxt, wr_go;
	logic [31:0] rdata_r, rdata_nxt;
	logic [15:0] tach_rd;
	logic        slow_evt, stall_evt;
	logic        ramp_en, step_to_off_enable;
	logic [2:0]  ramp_sel;

	assign ramp_en  = pctl_r[PC_RAMP_EN];
	assign step_to_off_enable     = pctl_r[PC_STEP_TO_OFF_ENABLE];
	assign ramp_sel = pctl_r[PC_SEL_LO +: 3];
	assign tick     = (div_r == 9'(TICK_DIV - 1));

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				m[8*i +: 8] = wd[8*i +: 8];
		return m;
	endfunction

	// Bus: every request is held off one cycle, then answered; writes land on that edge.
	assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
	assign wr_go           = avs_write && ack_r;
	assign avs_readdata    = rdata_r;

	always_comb begin
		logic [31:0] m;
		m         = 32'h0000_0000;
		ack_nxt   = (avs_read || avs_write) && !ack_r;
		rdata_nxt = rdata_r;
		pctl_nxt  = pctl_r;
		calc_nxt  = calc_r;
		tcfg_nxt  = tcfg_r;
		lim_nxt   = lim_r;
		// Hardware-set status bits win over a same-cycle write-one-to-clear.
		tst_nxt   = tst_r | {stall_evt, slow_evt};
		if (avs_read && !ack_r) begin
			case (avs_address)
				A_PWM_CTRL: rdata_nxt = {24'h000000, pctl_r};
				A_DUTY:     rdata_nxt = {24'h000000, calc_r};
				A_PRESENT:  rdata_nxt = {24'h000000, ramp_r};
				A_OUT_DUTY: rdata_nxt = {24'h000000, out_r};
				A_TACH_CFG: rdata_nxt = {19'h00000, tcfg_r};
				A_TACH_RD:  rdata_nxt = {16'h0000, tach_rd};
				A_TACH_ST:  rdata_nxt = {30'h00000000, tst_r};
				A_TACH_LIM: rdata_nxt = {16'h0000, lim_r};
				default:    rdata_nxt = 32'h0000_0000;
			endcase
		end
		if (wr_go) begin
			case (avs_address)
				A_PWM_CTRL: begin
					m        = merge({24'h000000, pctl_r}, avs_writedata, avs_byteenable);
					pctl_nxt = {3'b000, m[4:0]};
				end
				A_DUTY: begin
					m        = merge({24'h000000, calc_r}, avs_writedata, avs_byteenable);
					calc_nxt = m[7:0];
				end
				A_TACH_CFG: begin
					m        = merge({19'h00000, tcfg_r}, avs_writedata, avs_byteenable);
					tcfg_nxt = m[12:0];
				end
				A_TACH_LIM: begin
					m       = merge({16'h0000, lim_r}, avs_writedata, avs_byteenable);
					lim_nxt = m[15:0];
				end
				A_TACH_ST: begin
					if (avs_byteenable[0])
						tst_nxt = (tst_r & ~avs_writedata[1:0]) | {stall_evt, slow_evt};
				end
				default: ;
			endcase
		end
	end

	// Ramp engine, all on the 90 kHz tick.
	assign step_hit = (step_r >= 15'(STEP_TICKS[ramp_sel] - 1));

	always_comb begin
		div_nxt       = tick ? 9'h000 : div_r + 9'h001;
		step_nxt      = step_r;
		prev_calc_nxt = prev_calc_r;
		ramp_nxt      = ramp_r;
		out_nxt       = out_r;
		pcnt_nxt      = pcnt_r;
		if (tick) begin
			step_nxt      = step_hit ? 15'h0000 : step_r + 15'h0001;
			prev_calc_nxt = calc_r;
			pcnt_nxt      = pcnt_r + 8'h01;
			if (prev_calc_r == DUTY_OFF && calc_r != DUTY_OFF)
				ramp_nxt = calc_r;
			else if (!ramp_en)
				ramp_nxt = calc_r;
			else if (prev_calc_r != DUTY_OFF && calc_r == DUTY_OFF && !step_to_off_enable)
				ramp_nxt = DUTY_OFF;
			else if (step_hit && ramp_r < calc_r)
				ramp_nxt = ramp_r + 8'h01;
			else if (step_hit && ramp_r > calc_r)
				ramp_nxt = ramp_r - 8'h01;
			// The period restarts here, which is where the pin rises.
			if (pcnt_r == 8'hFF)
				out_nxt = ramp_nxt;
		end
	end

	assign pwm_out = (pcnt_r < out_r);

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			div_r       <= 9'h000;
			step_r      <= 15'h0000;
			prev_calc_r <= DUTY_OFF;
			ramp_r      <= DUTY_OFF;
			out_r       <= DUTY_OFF;
			pcnt_r      <= 8'h00;
			pctl_r      <= 8'h00;
			calc_r      <= DUTY_OFF;
			tcfg_r      <= {UPD_RST, GUARD_RST, IGN3_RST, EDGE_RST, SLOW_RST, MODE_RST};
			lim_r       <= LIM_RST;
			tst_r       <= 2'b00;
			ack_r       <= 1'b0;
			rdata_r     <= 32'h0000_0000;
		end else if (clk_en) begin
			div_r       <= div_nxt;
			step_r      <= step_nxt;
			prev_calc_r <= prev_calc_nxt;
			ramp_r      <= ramp_nxt;
			out_r       <= out_nxt;
			pcnt_r      <= pcnt_nxt;
			pctl_r      <= pctl_nxt;
			calc_r      <= calc_nxt;
			tcfg_r      <= tcfg_nxt;
			lim_r       <= lim_nxt;
			tst_r       <= tst_nxt;
			ack_r       <= ack_nxt;
			rdata_r     <= rdata_nxt;
		end
	end

	fpr_tach u_tach (
		.clk_sys   (clk_sys),
		.sys_rst   (sys_rst),
		.clk_en    (clk_en),
		.tick_90k  (tick),
		.tach_pin  (tach_pin),
		.mode_sel  (tcfg_r[TC_MODE]),
		.slow_opt  (tcfg_r[TC_SLOW]),
		.edge_sel  (tcfg_r[TC_EDGE_LO +: 2]),
		.pwm_high  (pwm_out),
		.reading   (tach_rd),
		.slow_evt  (slow_evt),
		.stall_evt (stall_evt)
	);

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	sequence s_on_tick;
		clk_en && tick;
	endsequence

	a_zero_load: assert property (s_on_tick ##0 prev_calc_r == DUTY_OFF && calc_r != DUTY_OFF
		|=> ramp_r == $past(calc_r))
		else $error("ramp duty not loaded on leaving zero");
	a_instant_off: assert property (s_on_tick ##0 ramp_en && !step_to_off_enable && prev_calc_r != DUTY_OFF
		&& calc_r == DUTY_OFF |=> ramp_r == DUTY_OFF)
		else $error("immediate off not taken");
	a_step_size: assert property (s_on_tick ##0 ramp_en && prev_calc_r == calc_r && step_hit
		&& ramp_r < calc_r |=> ramp_r == $past(ramp_r) + 8'h01)
		else $error("ramp step not one count");
	a_out_latch: assert property (s_on_tick ##0 pcnt_r == 8'hFF |=> out_r == ramp_r)
		else $error("output duty not latched at period start");
	a_out_hold: assert property (clk_en && !(tick && pcnt_r == 8'hFF) |=> $stable(out_r))
		else $error("output duty changed mid period");
	a_bus_answer: assert property (clk_en && avs_waitrequest |=> !avs_waitrequest || !clk_en)
		else $error("waitrequest held more than one cycle");
endmodule

/* testbench.sv */
// Purpose: Self-checking bench for the fan PWM ramp and tach monitor.
// Assumes: Ramp step times shortened to a few ticks; fan half period of six ticks.
// Notes:   Stall and slow results need 65535 ticks, far beyond this run's length.
`timescale 1ns/1ps
module testbench;
	import fpr_pkg::*;
	localparam int unsigned STEPS [8] = '{8, 7, 6, 5, 4, 3, 2, 1};
	localparam int          T = TICK_DIV;
	localparam int          NEDGE [4] = '{2, 3, 5, 9};
	localparam logic [31:0] CFG_RST = {19'h0, UPD_RST, GUARD_RST, IGN3_RST, EDGE_RST,
		SLOW_RST, MODE_RST};
	localparam logic [4:0]  RST_A [8] = '{A_PWM_CTRL, A_DUTY, A_PRESENT, A_OUT_DUTY,
		A_TACH_CFG, A_TACH_RD, A_TACH_ST, A_TACH_LIM};
	localparam logic [31:0] RST_E [8] = '{32'h0, 32'h0, 32'h0, 32'h0, CFG_RST,
		32'(TACH_MAX), 32'h0, 32'(LIM_RST)};
	logic        clk_sys;
	logic        sys_rst;
	logic [4:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        tach_pin;
	logic        pwm_out;
	logic [31:0] q;
	int          n_mismatch;
	int          compares;
	int          cyc;
	int          v;
	int          hi_cnt = 0;
	int          hi_len = 0;

	fpr_top #(.STEP_TICKS(STEPS)) dut (
		.clk_sys        (clk_sys),
		.sys_rst        (sys_rst),
		.clk_en         (1'h1),
		.avs_address    (avs_address),
		.avs_read       (avs_read),
		.avs_write      (avs_write),
		.avs_writedata  (avs_writedata),
		.avs_byteenable (4'hF),
		.avs_readdata   (avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.tach_pin       (tach_pin),
		.pwm_out        (pwm_out)
	);

	fpr_fan_model #(.HALF_CLKS(6 * T)) fan (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.tach_pin(tach_pin)
	);

	initial begin
		clk_sys = 1'h0;
		forever #20 clk_sys = ~clk_sys;
	end

	task automatic final_report;
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// The first PWM pulse starts near tick 256, where the first period ends, so it is timed in the background
	// while the tach checks run; waiting for it in line would push the run past its 98000-cycle limit.
	always @(posedge clk_sys) begin
		if (pwm_out === 1'h1)
			hi_cnt++;
		else if (hi_cnt > 0 && hi_len == 0)
			hi_len = hi_cnt;
	end

	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 98000) begin
			n_mismatch++;
			final_report;
		end
	end

	// Called just after a rising edge; the request stands until waitrequest is seen low.
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= wr;
		avs_read      <= ~wr;
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'h0) @(posedge clk_sys);
		q = avs_readdata;
		avs_write <= 1'h0;
		avs_read  <= 1'h0;
		@(posedge clk_sys);
	endtask

	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Tick phase against the bus is free, so a count may be one off either way.
	task automatic chk_near(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp && got !== exp + 32'h1 && got !== exp - 32'h1) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h near %h", $time, got, exp);
		end
	endtask

	task automatic rd(input logic [4:0] a, input logic [31:0] m);
		bus(1'h0, a, 32'h0);
		q = q & m;
	endtask

	task automatic wrv(input logic [4:0] a, input logic [31:0] d);
		bus(1'h1, a, d);
		rd(a, 32'h1FFF);
		chk_reg(q, d);
	endtask

	task automatic ticks(input int n);
		repeat (n * T) @(posedge clk_sys);
	endtask

	initial begin
		sys_rst       = 1'h1;
		avs_address   = 5'h00;
		avs_read      = 1'h0;
		avs_write     = 1'h0;
		avs_writedata = 32'h0;
		n_mismatch    = 0;
		compares      = 0;
		cyc           = 0;
		void'($urandom(22));
		repeat (20) @(posedge clk_sys);
		sys_rst <= 1'h0;
		@(posedge clk_sys);
		for (int i = 0; i < 8; i++) begin
			rd(RST_A[i], 32'hFFFF);
			chk_reg(q, RST_E[i]);
		end
		bus(1'h1, A_TACH_RD, 32'h1234);
		rd(A_TACH_RD, 32'hFFFF);
		chk_reg(q, 32'(TACH_MAX));
		wrv(A_PWM_CTRL, 32'h01);
		v = 16 + $urandom % 32;
		wrv(A_DUTY, 32'(v));
		ticks(3);
		rd(A_PRESENT, 32'hFF);
		chk_reg(q, 32'(v));
		for (int s = 0; s < 8; s++) begin
			wrv(A_PWM_CTRL, 32'(1 | s << PC_SEL_LO));
			v = (s % 2 == 0) ? v + 2 : v - 2;
			wrv(A_DUTY, 32'(v));
			rd(A_PRESENT, 32'hFF);
			chk_near(q, 32'((s % 2 == 0) ? v - 2 : v + 2));
			ticks(2 * STEPS[s] + 2);
			rd(A_PRESENT, 32'hFF);
			chk_reg(q, 32'(v));
		end
		wrv(A_PWM_CTRL, 32'h1D);
		wrv(A_DUTY, 32'h0);
		ticks(2);
		rd(A_PRESENT, 32'hFF);
		chk_reg(q, 32'h0);
		v = 12 + $urandom % 16;
		wrv(A_DUTY, 32'(v));
		ticks(2);
		rd(A_PRESENT, 32'hFF);
		chk_reg(q, 32'(v));
		wrv(A_PWM_CTRL, 32'h1F);
		wrv(A_DUTY, 32'h0);
		ticks(4);
		rd(A_PRESENT, 32'hFF);
		chk_near(q, 32'(v - 5));
		ticks(v);
		rd(A_PRESENT, 32'hFF);
		chk_reg(q, 32'h0);
		v = 24 + $urandom % 32;
		wrv(A_DUTY, 32'(v));
		for (int e = 0; e < 2; e++) begin
			wrv(A_TACH_CFG, (CFG_RST & ~32'hD) | 32'(e << TC_EDGE_LO));
			ticks(12 * NEDGE[e] + 4);
			for (int k = 0; k < 2; k++) begin
				rd(A_TACH_RD, 32'hFFFF);
				chk_near(q, 32'(6 * (NEDGE[e] - 1)));
				ticks(6 * NEDGE[e]);
			end
		end
		while (hi_len == 0) @(posedge clk_sys);
		rd(A_OUT_DUTY, 32'hFF);
		chk_reg(q, 32'(v));
		chk_near(32'((hi_len + T / 2) / T), 32'(v));
		rd(A_TACH_ST, 32'h3);
		chk_reg(q, 32'h0);
		final_report;
	end
endmodule
